// *** design/ccr_pkg.sv ***
// Package: constants and types of the configuration cycle router.
// Assumes the processor I/O port delivers doubleword-aligned addresses.
package ccr_pkg;

    localparam logic [15:0] IO_SEL_ADDR   = 16'h0cf8;
    localparam logic [15:0] IO_WIN_ADDR   = 16'h0cfc;
    localparam logic [3:0]  BE_DWORD      = 4'hf;
    localparam logic [31:0] SEL_RESET     = 32'h0000_0000;
    localparam logic [31:0] WIN_RESET     = 32'h0000_0000;
    localparam logic [31:0] SEL_WR_MASK   = 32'h80ff_fffc;
    localparam logic [31:0] UNCLAIMED     = 32'hffff_ffff;
    localparam int          EN_BIT        = 31;
    localparam int          BUS_HI        = 23;
    localparam int          BUS_LO        = 16;
    localparam int          DEV_HI        = 15;
    localparam int          DEV_LO        = 11;
    localparam int          FN_HI         = 10;
    localparam int          FN_LO         = 8;
    localparam int          REG_HI        = 7;
    localparam int          REG_LO        = 2;
    localparam int          IDSEL_BASE    = 16;
    localparam logic [4:0]  IDSEL_MAX_DEV = 5'h0f;
    localparam logic [4:0]  INT_MAX_DEV   = 5'h02;
    localparam logic [1:0]  CFG_T0_CODE   = 2'h0;
    localparam logic [1:0]  CFG_T1_CODE   = 2'h1;

    typedef enum logic [1:0] {
        LK_IO   = 2'h0,
        LK_CFG0 = 2'h1,
        LK_CFG1 = 2'h2
    } ccr_kind_type;

    typedef enum logic [2:0] {
        RT_INT  = 3'h0,
        RT_IGN  = 3'h1,
        RT_HL0  = 3'h2,
        RT_HL1  = 3'h3,
        RT_GFX0 = 3'h4,
        RT_GFX1 = 3'h5
    } ccr_route_type;

    typedef enum logic [3:0] {
        ST_IDLE     = 4'b0001,
        ST_WAIT_HL  = 4'b0010,
        ST_WAIT_GFX = 4'b0100,
        ST_WAIT_INT = 4'b1000
    } ccr_state_type;

    typedef struct packed {
        logic        valid;
        logic        wr;
        logic [15:0] addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } ccr_io_req_type;

    typedef struct packed {
        logic         req;
        logic         wr;
        ccr_kind_type kind;
        logic [31:0]  addr;
        logic [3:0]   be;
        logic [31:0]  wdata;
    } ccr_link_req_type;

    typedef struct packed {
        logic        done;
        logic        mabort;
        logic [31:0] rdata;
    } ccr_link_rsp_type;

endpackage : ccr_pkg

// *** design/ccr_route_dec.sv ***
// Route decoder: picks the path of a configuration access and builds
// the downstream address words. Purely combinational.
// Assumes bridge bus numbers are stable while an access is decoded.
`timescale 1ns/100ps
`default_nettype none
module ccr_route_dec
    import ccr_pkg::*;
(
    // Selector and bridge numbers
    input  wire logic [31:0]   i_sel,
    input  wire logic [7:0]    i_sec_bus,
    input  wire logic [7:0]    i_sub_bus,
    // Decode results
    output ccr_pkg::ccr_route_type o_route,
    output logic [31:0]        o_gfx_addr,
    output logic [31:0]        o_hl_addr
);
    logic [7:0] bus;
    logic [4:0] dev;
    logic [2:0] fn;
    logic [5:0] regn;

    always_comb begin
        bus  = i_sel[BUS_HI:BUS_LO];
        dev  = i_sel[DEV_HI:DEV_LO];
        fn   = i_sel[FN_HI:FN_LO];
        regn = i_sel[REG_HI:REG_LO];
        if (bus == 8'h00) begin
            if (dev <= INT_MAX_DEV) begin
                o_route = (fn == 3'h0) ? RT_INT : RT_IGN;
            end else begin
                o_route = RT_HL0;
            end
        end else if (bus == i_sec_bus) begin
            o_route = RT_GFX0;
        end else if (bus > i_sec_bus && bus <= i_sub_bus) begin
            o_route = RT_GFX1;
        end else begin
            o_route = RT_HL1;
        end
        o_gfx_addr = 32'h0000_0000;
        if (o_route == RT_GFX0) begin
            // one-hot select, none above device 15
            if (dev <= IDSEL_MAX_DEV) begin
                o_gfx_addr[IDSEL_BASE + 32'(dev[3:0])] = 1'b1;
            end
            o_gfx_addr[1:0] = CFG_T0_CODE;
        end else begin
            o_gfx_addr[BUS_HI:BUS_LO] = bus;
            o_gfx_addr[DEV_HI:DEV_LO] = dev;
            o_gfx_addr[1:0] = CFG_T1_CODE;
        end
        o_gfx_addr[FN_HI:FN_LO]   = fn;
        o_gfx_addr[REG_HI:REG_LO] = regn;
        o_hl_addr = {8'h00, bus, dev, fn, regn,
                     (o_route == RT_HL1) ? CFG_T1_CODE : CFG_T0_CODE};
    end

endmodule : ccr_route_dec
`default_nettype wire

// *** design/ccr_router.sv ***
// Configuration cycle router: selector and data window on the processor
// I/O port, routing to internal devices, hub link or graphics bus.
// Assumes one I/O request at a time; a request is offered only while
// o_io_busy is low, and each downstream agent answers with done.
`timescale 1ns/100ps
`default_nettype none
module ccr_router
    import ccr_pkg::*;
(
    // Clock and reset
    input  wire logic                      i_mclk,
    input  wire logic                      i_rst_b,
    // Processor I/O port
    input  wire ccr_pkg::ccr_io_req_type   i_io,
    output logic                           o_io_busy,
    output logic                           o_io_ack,
    output logic [31:0]                    o_io_rdata,
    // Bridge bus numbers
    input  wire logic [7:0]                i_sec_bus,
    input  wire logic [7:0]                i_sub_bus,
    // Hub link
    output ccr_pkg::ccr_link_req_type      o_hl,
    input  wire ccr_pkg::ccr_link_rsp_type i_hl,
    // Graphics bus
    output ccr_pkg::ccr_link_req_type      o_gfx,
    input  wire ccr_pkg::ccr_link_rsp_type i_gfx,
    output logic                           o_gfx_mabort_set,
    // Internal devices
    output ccr_pkg::ccr_link_req_type      o_int,
    input  wire ccr_pkg::ccr_link_rsp_type i_int,
    // Register views
    output logic [31:0]                    o_sel,
    output logic [31:0]                    o_window_value
);
    ccr_state_type  state_r;
    ccr_state_type  state_nxt;
    logic [31:0]    sel_r;
    logic [31:0]    win_r;
    ccr_route_type  route;
    logic [31:0]    gfx_addr;
    logic [31:0]    hl_addr;
    logic           take;
    logic           is_sel;
    logic           is_win;
    logic           sel_dw;
    logic           cfg_go;
    logic           fin;
    logic [31:0]    fin_data;
    logic           window_enable_bit;

    ccr_route_dec u_dec (
        .i_sel      (sel_r),
        .i_sec_bus  (i_sec_bus),
        .i_sub_bus  (i_sub_bus),
        .o_route    (route),
        .o_gfx_addr (gfx_addr),
        .o_hl_addr  (hl_addr)
    );

    assign window_enable_bit = sel_r[EN_BIT];
    assign take   = i_io.valid && (state_r == ST_IDLE);
    assign is_sel = i_io.addr == IO_SEL_ADDR;
    assign is_win = i_io.addr == IO_WIN_ADDR;
    assign sel_dw = is_sel && (i_io.be == BE_DWORD);
    assign cfg_go = is_win && window_enable_bit;

    always_comb begin
        state_nxt = state_r;
        fin       = 1'b0;
        fin_data  = UNCLAIMED;
        case (state_r)
            ST_IDLE: begin
                if (take && !sel_dw) begin
                    if (!cfg_go) begin
                        state_nxt = ST_WAIT_HL;
                    end else if (route == RT_INT) begin
                        state_nxt = ST_WAIT_INT;
                    end else if (route == RT_GFX0 || route == RT_GFX1) begin
                        state_nxt = ST_WAIT_GFX;
                    end else if (route == RT_HL0 || route == RT_HL1) begin
                        state_nxt = ST_WAIT_HL;
                    end
                end
            end
            ST_WAIT_HL: begin
                fin      = i_hl.done;
                fin_data = i_hl.rdata;
            end
            ST_WAIT_GFX: begin
                fin      = i_gfx.done;
                fin_data = i_gfx.mabort ? UNCLAIMED : i_gfx.rdata;
            end
            ST_WAIT_INT: begin
                fin      = i_int.done;
                fin_data = i_int.rdata;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (fin) begin
            state_nxt = ST_IDLE;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // selector capture, reserved bits forced zero
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sel_r <= SEL_RESET;
        end else if (take && sel_dw && i_io.wr) begin
            sel_r <= i_io.wdata & SEL_WR_MASK;
        end
    end

    // window holds last configuration data moved
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            win_r <= WIN_RESET;
        end else if (take && cfg_go && route == RT_IGN && !i_io.wr) begin
            win_r <= UNCLAIMED;
        end else if (take && cfg_go && i_io.wr) begin
            win_r <= i_io.wdata;
        end else if (fin && !o_hl.req && !o_gfx.req && !o_int.req) begin
            win_r <= win_r;
        end else if (fin && (o_gfx.req || o_int.req || o_hl.kind != LK_IO)
                     && !i_io_wr_pending()) begin
            win_r <= fin_data;
        end
    end

    function automatic logic i_io_wr_pending();
        return o_hl.req ? o_hl.wr : (o_gfx.req ? o_gfx.wr : o_int.wr);
    endfunction : i_io_wr_pending

    // Hub link request: plain I/O or configuration
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_hl <= '0;
        end else if (take && !sel_dw && !cfg_go) begin
            o_hl <= '{req: 1'b1, wr: i_io.wr, kind: LK_IO,
                      addr: {16'h0000, i_io.addr}, be: i_io.be,
                      wdata: i_io.wdata};
        end else if (take && cfg_go
                     && (route == RT_HL0 || route == RT_HL1)) begin
            o_hl <= '{req: 1'b1, wr: i_io.wr,
                      kind: (route == RT_HL1) ? LK_CFG1 : LK_CFG0,
                      addr: hl_addr, be: i_io.be, wdata: i_io.wdata};
        end else if (state_r == ST_WAIT_HL && i_hl.done) begin
            o_hl.req <= 1'b0;
        end
    end

    // Graphics bus request
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_gfx <= '0;
        end else if (take && cfg_go
                     && (route == RT_GFX0 || route == RT_GFX1)) begin
            o_gfx <= '{req: 1'b1, wr: i_io.wr,
                       kind: (route == RT_GFX1) ? LK_CFG1 : LK_CFG0,
                       addr: gfx_addr, be: i_io.be, wdata: i_io.wdata};
        end else if (state_r == ST_WAIT_GFX && i_gfx.done) begin
            o_gfx.req <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_gfx_mabort_set <= 1'b0;
        end else begin
            o_gfx_mabort_set <= state_r == ST_WAIT_GFX && i_gfx.done
                                && i_gfx.mabort;
        end
    end

    // internal request, kept off the hub link
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_int <= '0;
        end else if (take && cfg_go && route == RT_INT) begin
            o_int <= '{req: 1'b1, wr: i_io.wr, kind: LK_CFG0,
                       addr: hl_addr, be: i_io.be, wdata: i_io.wdata};
        end else if (state_r == ST_WAIT_INT && i_int.done) begin
            o_int.req <= 1'b0;
        end
    end

    // Answer to the processor
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_io_ack   <= 1'b0;
            o_io_rdata <= 32'h0000_0000;
        end else if (take && sel_dw) begin
            o_io_ack   <= 1'b1;
            o_io_rdata <= i_io.wr ? 32'h0000_0000 : sel_r;
        end else if (take && cfg_go && route == RT_IGN) begin
            o_io_ack   <= 1'b1;
            o_io_rdata <= i_io.wr ? 32'h0000_0000 : UNCLAIMED;
        end else if (fin) begin
            o_io_ack   <= 1'b1;
            o_io_rdata <= i_io_wr_pending() ? 32'h0000_0000 : fin_data;
        end else begin
            o_io_ack   <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_io_busy      <= 1'b0;
            o_sel          <= SEL_RESET;
            o_window_value <= WIN_RESET;
        end else begin
            o_io_busy      <= state_nxt != ST_IDLE
                              || (take && (sel_dw || route == RT_IGN));
            o_sel          <= sel_r;
            o_window_value <= win_r;
        end
    end

    // Checks
    // reserved bits zero
    chk_sel_reserved: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        sel_r[30:24] == 7'h00 && sel_r[1:0] == 2'h0)
        else $error("selector reserved bits not zero");

    chk_sel_capture: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        take && sel_dw && i_io.wr
        |=> sel_r == ($past(i_io.wdata) & SEL_WR_MASK))
        else $error("selector not captured on doubleword write");

    // partial write leaves selector and goes out as I/O
    chk_partial_pass: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        take && is_sel && !sel_dw |=> $stable(sel_r) && o_hl.req
        && o_hl.kind == LK_IO)
        else $error("partial selector access not passed through");

    // disabled window goes out as I/O
    chk_window_off: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        take && is_win && !window_enable_bit |=> o_hl.req && o_hl.kind == LK_IO
        && !o_gfx.req && !o_int.req)
        else $error("disabled window access not passed as I/O");

    chk_int_private: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        take && cfg_go && route == RT_INT |=> o_int.req && !o_hl.req
        ##1 !o_hl.req)
        else $error("internal access leaked to hub link");

    // one select line for devices 0 to 15
    chk_idsel_onehot: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        o_gfx.req && o_gfx.kind == LK_CFG0
        && $past(sel_r[DEV_HI]) == 1'b0 |-> $onehot(o_gfx.addr[31:16]))
        else $error("device select not one-hot");

    chk_idsel_none: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        take && cfg_go && route == RT_GFX0 && sel_r[DEV_HI]
        |=> o_gfx.addr[31:16] == 16'h0000)
        else $error("select driven for device above 15");

    // ignored access answered next cycle with no request
    chk_fn_ignore: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        take && cfg_go && route == RT_IGN |=> o_io_ack && !o_int.req
        && !o_hl.req && !o_gfx.req)
        else $error("non-zero function access to internal device not ignored");

    // hub-link cycle carries function and register
    chk_hl_fields: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        take && cfg_go && (route == RT_HL0 || route == RT_HL1)
        |=> o_hl.req
        && o_hl.addr[FN_HI:REG_LO] == $past(sel_r[FN_HI:REG_LO]))
        else $error("hub-link configuration fields wrong");

    // device field copied on graphics Type 1
    chk_gfx_type1: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        take && cfg_go && route == RT_GFX1 |=> o_gfx.req
        && o_gfx.kind == LK_CFG1
        && o_gfx.addr[DEV_HI:DEV_LO] == $past(sel_r[DEV_HI:DEV_LO]))
        else $error("graphics Type 1 device field wrong");

    chk_abort_record: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        state_r == ST_WAIT_GFX && i_gfx.done && i_gfx.mabort
        |=> o_gfx_mabort_set)
        else $error("master abort not recorded");

    cov_partial_pass: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
        take && is_sel && !sel_dw ##1 o_hl.req);
    cov_gfx_type1: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
        o_gfx.req && o_gfx.kind == LK_CFG1 ##[1:20] o_io_ack);
    cov_hl_type1: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
        o_hl.req && o_hl.kind == LK_CFG1);
    cov_int_done: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
        o_int.req ##[1:20] o_io_ack);

endmodule : ccr_router
`default_nettype wire

// *** sim/ccr_agent_model.sv ***
// Downstream agent model for hub link, graphics bus or internal devices.
// Assumes the request stays up until the cycle after done.
`timescale 1ns/100ps
`default_nettype none
module ccr_agent_model
    import ccr_pkg::*;
(
    // Clock and reset
    input  wire logic                      i_mclk,
    input  wire logic                      i_rst_b,
    // Link request and answer
    input  wire ccr_pkg::ccr_link_req_type i_req,
    output ccr_pkg::ccr_link_rsp_type      o_rsp,
    // Behaviour controls
    input  wire logic [3:0]                i_wait,
    input  wire logic                      i_mabort
);
    logic [3:0]  cnt_r;
    logic        ans_r;
    logic        done_r;
    logic [31:0] data_r;

    // One answer per request; data toggles when idle or after the answer, holds while waiting
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_r  <= 4'h0;
            ans_r  <= 1'b0;
            done_r <= 1'b0;
            data_r <= 32'h0000_0000;
        end else begin
            done_r <= 1'b0;
            if (i_req.req !== 1'b1) begin
                cnt_r  <= 4'h0;
                ans_r  <= 1'b0;
                data_r <= ~data_r;
            end else if (!ans_r && cnt_r == i_wait) begin
                done_r <= 1'b1;
                ans_r  <= 1'b1;
                data_r <= i_req.addr ^ 32'h5a5a_a5a5;
            end else if (!ans_r) begin
                cnt_r <= cnt_r + 4'h1;
            end else begin
                data_r <= ~data_r;
            end
        end
    end

    assign o_rsp = '{done: done_r, mabort: done_r & i_mabort, rdata: data_r};
endmodule : ccr_agent_model
`default_nettype wire

// *** sim/test_ccr_router.sv ***
// Testbench of the configuration cycle router: selector and window
// accesses through the I/O port, with agent models on all three links.
// Assumes ccr_pkg and the router; link 0 hub, 1 graphics, 2 internal.
`timescale 1ns/100ps
`default_nettype none
module test_ccr_router;
    import ccr_pkg::*;
    logic             i_mclk;
    logic             i_rst_b;
    ccr_io_req_type   io_r;
    logic             busy;
    logic             ack;
    logic             mab_set;
    logic [31:0]      rdata;
    logic [31:0]      sel_v;
    logic [31:0]      win_v;
    logic [31:0]      rd;
    logic [7:0]       sec_bus;
    logic [7:0]       sub_bus;
    logic [3:0]       agent_wait;
    logic             agent_mab;
    ccr_link_req_type rq [3];
    ccr_link_rsp_type rsp [3];
    ccr_link_req_type seen [3];
    logic             rq_q [3];
    int               cnt [3];
    int               c0;
    int               mab_cnt;
    int               error_cnt;
    int               tests_run;

    ccr_router ccr_router_i (
        .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_io(io_r), .o_io_busy(busy),
        .o_io_ack(ack), .o_io_rdata(rdata), .i_sec_bus(sec_bus),
        .i_sub_bus(sub_bus), .o_hl(rq[0]), .i_hl(rsp[0]), .o_gfx(rq[1]),
        .i_gfx(rsp[1]), .o_gfx_mabort_set(mab_set), .o_int(rq[2]),
        .i_int(rsp[2]), .o_sel(sel_v), .o_window_value(win_v));

    for (genvar k = 0; k < 3; k++) begin : g_agent
        ccr_agent_model ccr_agent_model_i (
            .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_req(rq[k]),
            .o_rsp(rsp[k]), .i_wait(agent_wait),
            .i_mabort(agent_mab && (k == 1)));
    end

    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    // Records each new request on every link
    always @(posedge i_mclk) begin
        for (int k = 0; k < 3; k++) begin
            if (rq[k].req === 1'b1 && rq_q[k] !== 1'b1) begin
                cnt[k] <= cnt[k] + 1;
                seen[k] <= rq[k];
            end
            rq_q[k] <= rq[k].req;
        end
        if (mab_set === 1'b1) mab_cnt <= mab_cnt + 1;
    end

    task automatic chk(input string what, input logic [31:0] sv,
                       input logic [31:0] ev);
        tests_run++;
        if (sv !== ev) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, ev, sv);
        end
    endtask : chk

    task automatic test_done();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    // One I/O request at a falling edge, then a bounded wait for ack
    task automatic io(input logic wr, input logic [15:0] addr,
                      input logic [3:0] be, input logic [31:0] wd,
                      output logic [31:0] rv);
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 100) begin
            @(negedge i_mclk);
            n++;
        end
        io_r <= '{valid: 1'b1, wr: wr, addr: addr, be: be, wdata: wd};
        @(negedge i_mclk);
        io_r.valid <= 1'b0;
        while (ack !== 1'b1 && n < 100) begin
            @(negedge i_mclk);
            n++;
        end
        if (n >= 100) begin
            error_cnt++;
            $display("ERROR io ack expected 1 seen 0");
            test_done();
        end
        rv = rdata;
        @(negedge i_mclk);
    endtask : io

    // Selects a target, then reads and writes the window; lk 3 is none
    task automatic run_case(input logic [7:0] bus, input logic [4:0] dev,
                            input logic [2:0] fn, input logic [5:0] rg,
                            input int lk, input ccr_kind_type kd,
                            input logic mab);
        logic [31:0] ea;
        logic [31:0] er;
        logic [31:0] rv;
        int          c [3];
        int          m0;
        if (lk == 1 && kd == LK_CFG0) begin
            ea = ((dev > 5'h0f) ? 32'h0 : (32'h1 << (16 + dev)));
            ea = ea | {21'h0, fn, rg, 2'b00};
        end else begin
            ea = {8'h00, bus, dev, fn, rg, 1'b0, kd == LK_CFG1};
        end
        er = (lk == 3 || mab) ? 32'hffff_ffff : ea ^ 32'h5a5a_a5a5;
        io(1'b1, 16'h0cf8, 4'hf, {1'b1, 7'h00, bus, dev, fn, rg, 2'b00}, rv);
        for (int w = 0; w < 2; w++) begin
            c = cnt;
            m0 = mab_cnt;
            io(w[0], 16'h0cfc, 4'hf, ~ea, rv);
            for (int k = 0; k < 3; k++) begin
                chk("link count", 32'(cnt[k] - c[k]), 32'(k == lk));
            end
            chk("abort pulse", 32'(mab_cnt - m0), 32'(mab));
            if (lk < 3) begin
                chk("link addr", seen[lk].addr, ea);
                chk("link wr", 32'(seen[lk].wr), 32'(w));
                chk("window", win_v, w ? ~ea : er);
                if (w) chk("link wdata", seen[lk].wdata, ~ea);
                if (lk != 2) chk("kind", 32'(seen[lk].kind), 32'(kd));
            end
            if (w == 0) chk("read data", rv, er);
        end
    endtask : run_case

    initial begin
        io_r = '0;
        i_rst_b = 1'b0;
        sec_bus = 8'h04;
        sub_bus = 8'h06;
        agent_wait = 4'h0;
        agent_mab = 1'b0;
        repeat (8) @(negedge i_mclk);
        i_rst_b = 1'b1;
        chk("sel reset", sel_v, 32'h0000_0000);
        chk("window reset", win_v, 32'h0000_0000);
        io(1'b1, 16'h0cf8, 4'hf, 32'hffff_ffff, rd);
        chk("sel write", sel_v, 32'h80ff_fffc);
        chk("busy idle", 32'(busy), 32'h0);
        io(1'b0, 16'h0cf8, 4'hf, 32'h0, rd);
        chk("sel read", rd, 32'h80ff_fffc);
        c0 = cnt[0];
        io(1'b1, 16'h0cf8, 4'h3, 32'h1234_5678, rd);
        chk("sel partial", sel_v, 32'h80ff_fffc);
        chk("partial count", 32'(cnt[0] - c0), 32'h1);
        chk("partial addr", seen[0].addr, 32'h0000_0cf8);
        chk("partial kind", 32'(seen[0].kind), 32'(LK_IO));
        chk("partial be", 32'(seen[0].be), 32'h3);
        chk("partial wdata", seen[0].wdata, 32'h1234_5678);
        io(1'b1, 16'h0cf8, 4'hf, 32'h0000_0800, rd);
        agent_wait = 4'h5;
        c0 = cnt[1] + cnt[2];
        io(1'b0, 16'h0cfc, 4'hf, 32'h0, rd);
        chk("off addr", seen[0].addr, 32'h0000_0cfc);
        chk("off kind", 32'(seen[0].kind), 32'(LK_IO));
        chk("off data", rd, 32'h5a5a_a959);
        chk("off cfg", 32'(cnt[1] + cnt[2] - c0), 32'h0);
        agent_wait = 4'h0;
        run_case(8'h00, 5'h00, 3'h0, 6'h03, 2, LK_CFG0, 1'b0);
        run_case(8'h00, 5'h02, 3'h0, 6'h3f, 2, LK_CFG0, 1'b0);
        run_case(8'h00, 5'h01, 3'h1, 6'h01, 3, LK_CFG0, 1'b0);
        run_case(8'h00, 5'h03, 3'h4, 6'h02, 0, LK_CFG0, 1'b0);
        agent_wait = 4'h6;
        run_case(8'h04, 5'h05, 3'h2, 6'h09, 1, LK_CFG0, 1'b0);
        run_case(8'h04, 5'h0f, 3'h7, 6'h3f, 1, LK_CFG0, 1'b0);
        agent_mab = 1'b1;
        run_case(8'h04, 5'h10, 3'h0, 6'h01, 1, LK_CFG0, 1'b1);
        agent_mab = 1'b0;
        run_case(8'h05, 5'h1f, 3'h3, 6'h04, 1, LK_CFG1, 1'b0);
        agent_wait = 4'h0;
        run_case(8'h06, 5'h07, 3'h0, 6'h08, 1, LK_CFG1, 1'b0);
        run_case(8'h07, 5'h09, 3'h5, 6'h10, 0, LK_CFG1, 1'b0);
        run_case(8'h03, 5'h0c, 3'h1, 6'h20, 0, LK_CFG1, 1'b0);
        i_rst_b = 1'b0;
        @(negedge i_mclk);
        i_rst_b = 1'b1;
        chk("sel rereset", sel_v, 32'h0000_0000);
        test_done();
    end
endmodule : test_ccr_router
`default_nettype wire
